// [core/etv_consts.svh]
`ifndef ETV_CONSTS_SVH
`define ETV_CONSTS_SVH
// register byte offsets on the bus
`define ETV_OFF_ICSR 8'h00
`define ETV_OFF_SHCR 8'h04
`define ETV_OFF_IENA 8'h08
`define ETV_OFF_IDIS 8'h0C
`define ETV_OFF_PRI_SYS 8'h10
`define ETV_OFF_PRI_IRQ0 8'h20
`define ETV_OFF_PEND 8'h40
`define ETV_OFF_STAT 8'h44
// interrupt control register fields
`define ETV_ICSR_NMI_SET 31
`define ETV_ICSR_PSV_SET 28
`define ETV_ICSR_PSV_CLR 27
`define ETV_ICSR_TICK_SET 26
`define ETV_ICSR_TICK_CLR 25
// system handler control fields
`define ETV_SHCR_MEM_EN 16
`define ETV_SHCR_BUS_EN 17
`define ETV_SHCR_USE_EN 18
`define ETV_SHCR_MON_EN 19
`define ETV_SHCR_SVC_EN 20
`define ETV_SHCR_PSV_EN 21
`define ETV_SHCR_TICK_EN 22
// vector numbers
`define ETV_VEC_RESET 6'h01
`define ETV_VEC_NMI 6'h02
`define ETV_VEC_HARD 6'h03
`define ETV_VEC_MEM 6'h04
`define ETV_VEC_BUS 6'h05
`define ETV_VEC_USAGE 6'h06
`define ETV_VEC_SVC 6'h0B
`define ETV_VEC_MON 6'h0C
`define ETV_VEC_PSV 6'h0E
`define ETV_VEC_TICK 6'h0F
`define ETV_VEC_IRQ0 6'h10
// vector table offsets
`define ETV_SP_OFFSET 32'h0000_0000
`define ETV_RESET_OFFSET 32'h0000_0004
// populated interrupt lines: ports 0-2, serial 5, sync serial 7, wdt 18,
// timers 19-22, comparators 25-26, sysctl 28, flash 29
`define ETV_IRQ_IMPL 30'h367C_00A7
`define ETV_PRI_RESET 3'h0
`endif

// [core/etv_pkg.sv]
package etv_pkg;
	localparam int ETV_NIRQ = 30;
	typedef logic [2:0] etv_pri_t;
	typedef struct packed {
		logic valid;
		logic [5:0] vector;
		logic [31:0] offset;
		logic [4:0] urgency;
	} etv_req_t;
	typedef struct packed {
		logic mem_fault;
		logic bus_fault;
		logic usage_fault;
		logic supervisor_call_instr;
		logic monitor;
		logic tick;
	} etv_sync_t;
	typedef enum logic [1:0] {
		ETV_ST_RESET = 2'b00,
		ETV_ST_FETCH_SP = 2'b01,
		ETV_ST_FETCH_PC = 2'b10,
		ETV_ST_RUN = 2'b11
	} etv_state_t;
endpackage : etv_pkg

// [core/etv_vector_unit.sv]
// Added by the designer: the Wishbone register port and the address map.
`include "etv_consts.svh"
module etv_vector_unit import etv_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic nmi_pin,
	input wire logic [ETV_NIRQ-1:0] irq_line,
	input wire etv_sync_t fault_in,
	input wire logic exc_error,
	input wire logic halting,
	input wire logic timer_zero,
	input wire logic timer_int_en,
	input wire logic core_fetch_done,
	input wire logic core_entered,
	input wire logic core_return,
	output logic core_halt,
	output logic core_privileged,
	output logic [31:0] core_fetch_addr,
	output logic core_fetch_sp,
	output logic core_fetch_pc,
	output etv_req_t exc_req,
	output logic [5:0] active_vector
);
	// nmi and hard fault, seven programmable system handlers, then the lines
	localparam int NSRC = 2 + 7 + ETV_NIRQ;
	localparam logic [29:0] IMPL = `ETV_IRQ_IMPL;

	etv_state_t state;
	logic [31:0] icsr_pend;
	logic [31:0] shcr;
	logic [ETV_NIRQ-1:0] irq_en;
	etv_pri_t pri_sys [7];
	etv_pri_t pri_irq [ETV_NIRQ];
	logic nmi_pend, hard_pend, psv_pend, tick_pend;
	logic [3:0] syncp;
	logic [ETV_NIRQ-1:0] irq_pend;
	logic [4:0] active_urg;
	logic in_handler;

	// urgency: fixed levels 0..2 (-3..-1), programmable p maps to p+3
	function automatic logic [4:0] urg_of(input etv_pri_t p);
		urg_of = 5'(p) + 5'h03;
	endfunction : urg_of

	function automatic logic [5:0] vec_of(input int i);
		logic [5:0] v;
		v = 6'h00;
		case (i)
			0: v = `ETV_VEC_NMI;
			1: v = `ETV_VEC_HARD;
			2: v = `ETV_VEC_MEM;
			3: v = `ETV_VEC_BUS;
			4: v = `ETV_VEC_USAGE;
			5: v = `ETV_VEC_SVC;
			6: v = `ETV_VEC_MON;
			7: v = `ETV_VEC_PSV;
			8: v = `ETV_VEC_TICK;
			default: v = `ETV_VEC_IRQ0 + 6'(i - 9);
		endcase
		vec_of = v;
	endfunction : vec_of

	// bus access
	wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire bus_wr = bus_req && wb_we_i && (wb_sel_i == 4'hF);
	wire wr_icsr = bus_wr && wb_adr_i == `ETV_OFF_ICSR;
	wire wr_shcr = bus_wr && wb_adr_i == `ETV_OFF_SHCR;
	wire wr_iena = bus_wr && wb_adr_i == `ETV_OFF_IENA;
	wire wr_idis = bus_wr && wb_adr_i == `ETV_OFF_IDIS;
	wire wr_psys = bus_wr && wb_adr_i[7:4] == 4'h1;
	wire wr_pirq = bus_wr && wb_adr_i[7:5] == 3'h1;
	wire [2:0] pri_idx = wb_adr_i[4:2];

	// event sources; set beats a clear in the same cycle
	wire sw_nmi = wr_icsr && wb_dat_i[`ETV_ICSR_NMI_SET];
	wire sw_psv = wr_icsr && wb_dat_i[`ETV_ICSR_PSV_SET];
	wire sw_psv_clr = wr_icsr && wb_dat_i[`ETV_ICSR_PSV_CLR];
	wire sw_tick = wr_icsr && wb_dat_i[`ETV_ICSR_TICK_SET];
	wire sw_tick_clr = wr_icsr && wb_dat_i[`ETV_ICSR_TICK_CLR];
	wire hw_tick = timer_zero && timer_int_en;
	// disabled configurable faults escalate to hard fault
	wire mem_esc = fault_in.mem_fault && !shcr[`ETV_SHCR_MEM_EN];
	wire bus_esc = fault_in.bus_fault && !shcr[`ETV_SHCR_BUS_EN];
	wire use_esc = fault_in.usage_fault && !shcr[`ETV_SHCR_USE_EN];
	wire hard_set = exc_error || mem_esc || bus_esc || use_esc;

	// source tables
	logic [NSRC-1:0] src_pend;
	logic [NSRC-1:0] src_en;
	logic [4:0] src_urg [NSRC];
	logic [5:0] src_vec [NSRC];
	assign src_pend[0] = nmi_pend;
	assign src_pend[1] = hard_pend;
	assign src_pend[2] = syncp[0];
	assign src_pend[3] = syncp[1];
	assign src_pend[4] = syncp[2];
	assign src_pend[5] = syncp[3];
	assign src_pend[6] = fault_in.monitor && !halting;
	assign src_pend[7] = psv_pend;
	assign src_pend[8] = tick_pend;
	assign src_en[0] = 1'b1;
	assign src_en[1] = 1'b1;
	assign src_en[2] = shcr[`ETV_SHCR_MEM_EN];
	assign src_en[3] = shcr[`ETV_SHCR_BUS_EN];
	assign src_en[4] = shcr[`ETV_SHCR_USE_EN];
	assign src_en[5] = shcr[`ETV_SHCR_SVC_EN];
	assign src_en[6] = shcr[`ETV_SHCR_MON_EN];
	assign src_en[7] = shcr[`ETV_SHCR_PSV_EN];
	assign src_en[8] = shcr[`ETV_SHCR_TICK_EN];
	assign src_urg[0] = 5'h01;
	assign src_urg[1] = 5'h02;
	genvar g;
	generate
		for (g = 2; g < 9; g++) begin : g_sys
			assign src_urg[g] = urg_of(pri_sys[g-2]);
		end
		for (g = 0; g < ETV_NIRQ; g++) begin : g_irq
			assign src_pend[9+g] = irq_pend[g];
			assign src_en[9+g] = irq_en[g] && IMPL[g];
			assign src_urg[9+g] = urg_of(pri_irq[g]);
		end
		for (g = 0; g < NSRC; g++) begin : g_vec
			assign src_vec[g] = vec_of(g);
		end
	endgenerate

	// sources sit in vector-number order, so strict compare keeps lowest number
	logic [4:0] best_urg;
	logic [5:0] best_vec;
	logic best_ok;
	always_comb begin
		best_ok = 1'b0;
		best_urg = 5'h1F;
		best_vec = 6'h00;
		for (int i = 0; i < NSRC; i++) begin
			if (src_pend[i] && src_en[i] && (!best_ok || src_urg[i] < best_urg)) begin
				best_ok = 1'b1;
				best_urg = src_urg[i];
				best_vec = src_vec[i];
			end
		end
	end

	// equal urgency never preempts; latched flags and lines stay pending, one-cycle sync faults are lost
	wire can_take = best_ok && state == ETV_ST_RUN && (!in_handler || best_urg < active_urg);
	wire [5:0] win_vec = can_take ? best_vec : 6'h00;
	wire take = can_take && core_entered;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			exc_req <= '0;
		end else begin
			exc_req.valid <= can_take;
			exc_req.vector <= win_vec;
			exc_req.offset <= {24'h0, win_vec, 2'b00};
			exc_req.urgency <= can_take ? best_urg : 5'h1F;
		end
	end

	// reset sequence: stack pointer word then reset vector
	etv_state_t next_state;
	always_comb begin
		case (state)
			ETV_ST_RESET: next_state = ETV_ST_FETCH_SP;
			ETV_ST_FETCH_SP: next_state = core_fetch_done ? ETV_ST_FETCH_PC : ETV_ST_FETCH_SP;
			ETV_ST_FETCH_PC: next_state = core_fetch_done ? ETV_ST_RUN : ETV_ST_FETCH_PC;
			ETV_ST_RUN: next_state = ETV_ST_RUN;
			default: next_state = ETV_ST_RESET;
		endcase
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= ETV_ST_RESET;
		end else begin
			state <= next_state;
		end
	end
	assign core_halt = rst || state != ETV_ST_RUN;
	assign core_fetch_sp = state == ETV_ST_FETCH_SP;
	assign core_fetch_pc = state == ETV_ST_FETCH_PC;
	assign core_fetch_addr = core_fetch_pc ? `ETV_RESET_OFFSET : `ETV_SP_OFFSET;

	// one level of activation is tracked; nesting depth is the core's business
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			in_handler <= 1'b0;
			active_urg <= 5'h1F;
			active_vector <= 6'h00;
			core_privileged <= 1'b1;
		end else if (take) begin
			in_handler <= 1'b1;
			active_urg <= best_urg;
			active_vector <= best_vec;
			core_privileged <= 1'b1;
		end else if (core_return) begin
			in_handler <= 1'b0;
			active_urg <= 5'h1F;
			active_vector <= 6'h00;
		end
	end
	wire clr_take_vec = take ? 1'b1 : 1'b0;

	// pending flags: set wins over clear and over acceptance
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			nmi_pend <= 1'b0;
			hard_pend <= 1'b0;
			psv_pend <= 1'b0;
			tick_pend <= 1'b0;
			syncp <= 4'h0;
		end else begin
			nmi_pend <= nmi_pin || sw_nmi || (nmi_pend && !(clr_take_vec && best_vec == `ETV_VEC_NMI));
			hard_pend <= hard_set || (hard_pend && !(take && best_vec == `ETV_VEC_HARD));
			psv_pend <= sw_psv || (psv_pend && !sw_psv_clr && !(take && best_vec == `ETV_VEC_PSV));
			tick_pend <= hw_tick || sw_tick
				|| (tick_pend && !sw_tick_clr && !(take && best_vec == `ETV_VEC_TICK));
			syncp[0] <= fault_in.mem_fault && shcr[`ETV_SHCR_MEM_EN];
			syncp[1] <= fault_in.bus_fault && shcr[`ETV_SHCR_BUS_EN];
			syncp[2] <= fault_in.usage_fault && shcr[`ETV_SHCR_USE_EN];
			syncp[3] <= fault_in.supervisor_call_instr;
		end
	end
	// the core may retire one more instruction before asserting core_entered
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_pend <= '0;
		end else begin
			for (int i = 0; i < ETV_NIRQ; i++) begin
				irq_pend[i] <= (irq_line[i] && IMPL[i])
					|| (irq_pend[i] && !(take && best_vec == `ETV_VEC_IRQ0 + 6'(i)));
			end
		end
	end

	// configuration registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			shcr <= 32'h0000_0000;
			irq_en <= '0;
			for (int i = 0; i < 7; i++) pri_sys[i] <= `ETV_PRI_RESET;
			for (int i = 0; i < ETV_NIRQ; i++) pri_irq[i] <= `ETV_PRI_RESET;
		end else begin
			if (wr_shcr) shcr <= wb_dat_i;
			if (wr_iena) irq_en <= irq_en | wb_dat_i[ETV_NIRQ-1:0];
			if (wr_idis) irq_en <= irq_en & ~wb_dat_i[ETV_NIRQ-1:0];
			if (wr_psys && pri_idx < 3'h7) pri_sys[pri_idx] <= wb_dat_i[2:0];
			if (wr_pirq) begin
				for (int i = 0; i < ETV_NIRQ; i++) begin
					if (3'(i) == wb_adr_i[4:2] && i < 8) pri_irq[i] <= wb_dat_i[2:0];
				end
			end
		end
	end
	assign icsr_pend = {nmi_pend, 2'b00, psv_pend, 1'b0, tick_pend, 1'b0, 19'h0, can_take ? best_vec : 6'h00};

	// read mux
	logic [31:0] rd;
	always_comb begin
		rd = 32'h0000_0000;
		case (wb_adr_i)
			`ETV_OFF_ICSR: rd = icsr_pend;
			`ETV_OFF_SHCR: rd = shcr;
			`ETV_OFF_IENA: rd = {2'b00, irq_en};
			`ETV_OFF_IDIS: rd = {2'b00, irq_en};
			`ETV_OFF_PEND: rd = {2'b00, irq_pend};
			`ETV_OFF_STAT: rd = {25'h0, in_handler, active_vector};
			default: begin
				if (wb_adr_i[7:4] == 4'h1 && pri_idx < 3'h7) rd = {29'h0, pri_sys[pri_idx]};
				else rd = 32'h0000_0000;
			end
		endcase
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= rd;
		end
	end

	a_halt_on_reset: assert property (@(posedge ref_clk) rst |-> core_halt)
		else $error("core not halted in reset");
	sequence s_sp_fetch;
		core_fetch_sp && core_fetch_addr == 32'h0000_0000;
	endsequence
	a_boot_sp_first: assert property (@(posedge ref_clk) $fell(rst) |=> s_sp_fetch)
		else $error("stack pointer not fetched first");
	a_boot_pc_addr: assert property (@(posedge ref_clk) disable iff (rst)
		core_fetch_pc |-> core_fetch_addr == 32'h0000_0004 && core_privileged)
		else $error("reset vector address wrong");
	a_nmi_wins: assert property (@(posedge ref_clk) disable iff (rst)
		nmi_pend && state == ETV_ST_RUN && !(in_handler && active_urg <= 5'h01)
		|=> exc_req.valid && exc_req.vector == 6'h02)
		else $error("nmi not presented");
	a_no_equal_preempt: assert property (@(posedge ref_clk) disable iff (rst)
		can_take && in_handler |-> best_urg < active_urg)
		else $error("equal priority preempted");
	a_irq_offset: assert property (@(posedge ref_clk) disable iff (rst)
		exc_req.valid |-> exc_req.offset == {24'h0, exc_req.vector, 2'b00})
		else $error("vector offset mismatch");
	a_hard_escalate: assert property (@(posedge ref_clk) disable iff (rst)
		exc_error |=> hard_pend)
		else $error("hard fault not pended");
	a_tick_pend: assert property (@(posedge ref_clk) disable iff (rst)
		hw_tick |=> tick_pend)
		else $error("tick not pended");
	a_reserved_line: assert property (@(posedge ref_clk) disable iff (rst)
		irq_line[3] |=> !irq_pend[3])
		else $error("reserved line pended");
	sequence s_pc_fetch;
		core_fetch_pc && core_fetch_addr == `ETV_RESET_OFFSET;
	endsequence
	a_boot_pc_next: assert property (@(posedge ref_clk) disable iff (rst)
		core_fetch_sp && core_fetch_done |=> s_pc_fetch)
		else $error("reset vector not fetched after stack pointer");
	a_boot_run: assert property (@(posedge ref_clk) disable iff (rst)
		core_fetch_pc && core_fetch_done |=> !core_halt && core_privileged)
		else $error("core not released into privileged run");
	a_prio_reset: assert property (@(posedge ref_clk)
		$fell(rst) |-> pri_sys[0] == `ETV_PRI_RESET && pri_irq[0] == `ETV_PRI_RESET)
		else $error("priority not zero after reset");
	a_psv_sw_only: assert property (@(posedge ref_clk) disable iff (rst)
		!psv_pend && !sw_psv |=> !psv_pend)
		else $error("service request pended without write");
	a_mon_halting: assert property (@(posedge ref_clk) disable iff (rst)
		halting |=> !(exc_req.valid && exc_req.vector == `ETV_VEC_MON))
		else $error("monitor presented while halting");
	a_equal_holds: assert property (@(posedge ref_clk) disable iff (rst)
		in_handler && best_ok && best_urg >= active_urg |=> !exc_req.valid)
		else $error("request presented without more urgency");
	a_idle_no_req: assert property (@(posedge ref_clk) disable iff (rst)
		!best_ok |=> !exc_req.valid)
		else $error("request with nothing pending");
	a_hard_first: assert property (@(posedge ref_clk) disable iff (rst)
		hard_pend && state == ETV_ST_RUN && !in_handler
		|=> exc_req.valid && (exc_req.vector == `ETV_VEC_NMI || exc_req.vector == `ETV_VEC_HARD))
		else $error("hard fault passed over");
	a_irq_base: assert property (@(posedge ref_clk) disable iff (rst)
		exc_req.valid && exc_req.vector >= `ETV_VEC_IRQ0 |-> exc_req.offset >= 32'h0000_0040)
		else $error("interrupt offset below base");
	a_ack_pulse: assert property (@(posedge ref_clk) disable iff (rst)
		wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge longer than one cycle");
endmodule : etv_vector_unit

// [dv/etv_core_model.sv]
module etv_core_model import etv_pkg::*; #(
	parameter int FETCH_DLY = 2
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic core_fetch_sp,
	input wire logic core_fetch_pc,
	input wire etv_req_t exc_req,
	input wire logic take,
	output logic core_fetch_done,
	output logic core_entered,
	output etv_req_t taken_req
);
	logic [3:0] cnt;
	logic fetching;
	logic ent_d;
	logic accept;
	assign fetching = core_fetch_sp | core_fetch_pc;
	// two quiet cycles after entry so a stale request register is not taken twice
	assign accept = take & exc_req.valid & ~core_entered & ~ent_d;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt <= 4'h0;
			core_fetch_done <= 1'h0;
			core_entered <= 1'h0;
			ent_d <= 1'h0;
			taken_req <= '0;
		end else begin
			// slow memory: boot word arrives FETCH_DLY cycles late
			core_fetch_done <= fetching & ~core_fetch_done & (cnt == 4'(FETCH_DLY));
			cnt <= (fetching & ~core_fetch_done & (cnt != 4'(FETCH_DLY))) ? cnt + 4'h1 : 4'h0;
			core_entered <= accept;
			ent_d <= core_entered;
			if (accept)
				taken_req <= exc_req;
		end
	end
endmodule : etv_core_model

// [dv/tb.sv]
module tb import etv_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// populated lines, reserved ones must never be presented
	localparam logic [29:0] IMPL = 30'h367C_00A7;
	logic ref_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, nmi_pin, exc_error, halting;
	logic timer_zero, timer_int_en, core_entered, core_return, core_halt, core_privileged;
	logic core_fetch_sp, core_fetch_pc, core_fetch_done, take;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [3:0] wsel = 4'hF;
	logic [31:0] wb_dat_i, wb_dat_o, core_fetch_addr, q;
	logic [ETV_NIRQ-1:0] irq_line;
	logic [5:0] active_vector;
	etv_sync_t fault_in;
	etv_req_t exc_req, taken_req;
	int bad_count, n_tests, cyc_cnt, k;
	etv_vector_unit etv_vector_unit_inst(.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .nmi_pin(nmi_pin),
		.irq_line(irq_line), .fault_in(fault_in), .exc_error(exc_error), .halting(halting),
		.timer_zero(timer_zero), .timer_int_en(timer_int_en), .core_fetch_done(core_fetch_done),
		.core_entered(core_entered), .core_return(core_return), .core_halt(core_halt),
		.core_privileged(core_privileged), .core_fetch_addr(core_fetch_addr),
		.core_fetch_sp(core_fetch_sp), .core_fetch_pc(core_fetch_pc), .exc_req(exc_req),
		.active_vector(active_vector));
	etv_core_model etv_core_model_inst(.ref_clk(ref_clk), .rst(rst), .core_fetch_sp(core_fetch_sp),
		.core_fetch_pc(core_fetch_pc), .exc_req(exc_req), .take(take),
		.core_fetch_done(core_fetch_done), .core_entered(core_entered), .taken_req(taken_req));
	initial begin
		ref_clk = 1'h0;
		forever #50 ref_clk = ~ref_clk;
	end
	task give_verdict;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	always @(posedge ref_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			bad_count++;
			give_verdict();
		end
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
		@(posedge ref_clk);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_sel_i <= wsel;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		do @(posedge ref_clk); while (wb_ack_o !== 1'h1);
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		wb_we_i <= 1'h0;
	endtask : wb
	task rdc(input string nm, input logic [7:0] adr, input logic [31:0] exp);
		wb(1'h0, adr, 32'h0);
		chk(nm, q, exp);
	endtask : rdc
	task take_vec(input logic [5:0] vec);
		for (k = 0; k < 12 && core_entered !== 1'h1; k++)
			@(posedge ref_clk);
		chk("entered", {31'h0, core_entered}, 32'h1);
		chk("vector", {26'h0, taken_req.vector}, {26'h0, vec});
		chk("offset", taken_req.offset, {24'h0, vec, 2'h0});
	endtask : take_vec
	task none(input string nm);
		logic hit;
		hit = 1'h0;
		repeat (8) begin
			@(posedge ref_clk);
			if (core_entered !== 1'h0)
				hit = 1'h1;
		end
		chk(nm, {31'h0, hit}, 32'h0);
	endtask : none
	task ret;
		@(posedge ref_clk);
		core_return <= 1'h1;
		@(posedge ref_clk);
		core_return <= 1'h0;
	endtask : ret
	task pf(input int i);
		@(posedge ref_clk);
		fault_in <= etv_sync_t'(6'h01 << i);
		@(posedge ref_clk);
		fault_in <= '0;
	endtask : pf
	// a held line re-pends after entry, so lines are only pulsed
	task irq_pulse(input logic [ETV_NIRQ-1:0] m);
		@(posedge ref_clk);
		irq_line <= m;
		@(posedge ref_clk);
		irq_line <= '0;
	endtask : irq_pulse
	int fidx[4] = '{5, 4, 3, 2};
	logic [5:0] fvec[4] = '{6'h04, 6'h05, 6'h06, 6'h0B};
	initial begin
		{rst, take} = 2'h2;
		{wb_cyc_i, wb_stb_i, wb_we_i, nmi_pin, exc_error, halting} = 6'h00;
		{timer_zero, timer_int_en, core_return} = 3'h0;
		{wb_adr_i, wb_dat_i, irq_line, fault_in} = '0;
		wb_sel_i = 4'hF;
		repeat (10) @(posedge ref_clk);
		chk("halt_in_reset", {31'h0, core_halt}, 32'h1);
		rst <= 1'h0;
		for (k = 0; k < 20 && core_fetch_sp !== 1'h1; k++) @(posedge ref_clk);
		chk("sp_fetch", {31'h0, core_fetch_sp}, 32'h1);
		chk("sp_addr", core_fetch_addr, 32'h0000_0000);
		for (k = 0; k < 20 && core_fetch_pc !== 1'h1; k++) @(posedge ref_clk);
		chk("pc_addr", core_fetch_addr, 32'h0000_0004);
		for (k = 0; k < 20 && core_halt !== 1'h0; k++) @(posedge ref_clk);
		chk("run", {31'h0, core_halt}, 32'h0);
		chk("privileged", {31'h0, core_privileged}, 32'h1);
		take <= 1'h1;
		rdc("handler_enables", 8'h04, 32'h0);
		for (int a = 16; a <= 60; a += 4) rdc("priority", 8'(a), 32'h0);
		wb(1'h1, 8'h80, 32'hFFFF_FFFF);
		rdc("unmapped", 8'h80, 32'h0);
		nmi_pin <= 1'h1;
		@(posedge ref_clk);
		nmi_pin <= 1'h0;
		take_vec(6'h02);
		chk("nmi_urgency", {27'h0, taken_req.urgency}, 32'h1);
		@(posedge ref_clk);
		chk("active_vector", {26'h0, active_vector}, 32'h2);
		ret();
		wb(1'h1, 8'h00, 32'h8000_0000);
		take_vec(6'h02);
		ret();
		exc_error <= 1'h1;
		@(posedge ref_clk);
		exc_error <= 1'h0;
		take_vec(6'h03);
		ret();
		pf(5);
		take_vec(6'h03);
		ret();
		pf(2);
		none("svc_disabled");
		wsel = 4'h3;
		wb(1'h1, 8'h04, 32'h007F_0000);
		wsel = 4'hF;
		rdc("sel_refused", 8'h04, 32'h0);
		wb(1'h1, 8'h04, 32'h007F_0000);
		for (int i = 0; i < 4; i++) begin
			pf(fidx[i]);
			take_vec(fvec[i]);
			ret();
		end
		halting <= 1'h1;
		fault_in <= etv_sync_t'(6'h02);
		none("monitor_halting");
		halting <= 1'h0;
		take_vec(6'h0C);
		fault_in <= '0;
		ret();
		wb(1'h1, 8'h00, 32'h1000_0000);
		take_vec(6'h0E);
		ret();
		{timer_zero, timer_int_en} <= 2'h3;
		@(posedge ref_clk);
		timer_zero <= 1'h0;
		take_vec(6'h0F);
		ret();
		wb(1'h1, 8'h00, 32'h0400_0000);
		take_vec(6'h0F);
		ret();
		wb(1'h1, 8'h08, 32'h3FFF_FFFF);
		for (int n = 0; n < 30; n++) begin
			irq_pulse(30'h1 << n);
			if (IMPL[n]) begin
				take_vec(6'(16 + n));
				ret();
			end else
				none("reserved_line");
		end
		irq_pulse(30'h3);
		take_vec(6'h10);
		ret();
		take_vec(6'h11);
		ret();
		wb(1'h1, 8'h20, 32'h0000_0002);
		irq_pulse(30'h3);
		take_vec(6'h11);
		ret();
		take_vec(6'h10);
		ret();
		irq_pulse(30'h20);
		take_vec(6'h15);
		irq_pulse(30'h80);
		none("same_priority");
		nmi_pin <= 1'h1;
		@(posedge ref_clk);
		nmi_pin <= 1'h0;
		take_vec(6'h02);
		ret();
		take_vec(6'h17);
		ret();
		wb(1'h1, 8'h0C, 32'h0000_0020);
		irq_pulse(30'h20);
		none("irq_disabled");
		wb(1'h1, 8'h10, 32'h0000_0005);
		rdc("sys_priority", 8'h10, 32'h5);
		rdc("pend_disabled", 8'h40, 32'h0000_0020);
		@(posedge ref_clk);
		rst <= 1'h1;
		@(posedge ref_clk);
		chk("halt_mid_reset", {31'h0, core_halt}, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk("req_mid_reset", {31'h0, exc_req.valid}, 32'h0);
		rst <= 1'h0;
		for (k = 0; k < 20 && core_fetch_sp !== 1'h1; k++) @(posedge ref_clk);
		chk("sp_refetch", {31'h0, core_fetch_sp}, 32'h1);
		for (k = 0; k < 20 && core_halt !== 1'h0; k++) @(posedge ref_clk);
		rdc("pri_after_reset", 8'h10, 32'h0);
		rdc("pend_after_reset", 8'h40, 32'h0);
		give_verdict();
	end
endmodule : tb
